/* File: dts_pkg.sv */
package dts_pkg;

	// Memory and pointer geometry
	localparam int        MEM_DEPTH    = 256;
	localparam int        PTR_W        = 8;
	localparam int        BYTE_W       = 8;
	localparam int        BITS_PER_BYTE = 8;

	// Diagnostics memory layout
	localparam logic [7:0] CFG_RATE_SEL_OFS = 8'h75;
	localparam int         CFG_RATE_BIT     = 0;
	localparam logic [7:0] CFG_RATE_RST     = 8'h00;
	// Locations at and above this offset hold factory data and ignore writes
	localparam logic [7:0] MEM_PROT_BASE    = 8'h80;

	// Seven-bit bus address of the management slave
	localparam logic [6:0] DEV_ADDR_DEF     = 7'h50;

	// Lock timing of the receive clock recovery unit
	localparam int CORE_CLK_MHZ  = 250;
	localparam int LOCK_TYP_MS   = 65;
	localparam int LOCK_MAX_MS   = 130;
	localparam int LOCK_TYP_CYC  = LOCK_TYP_MS * 1000 * CORE_CLK_MHZ;
	localparam int LOCK_MAX_CYC  = LOCK_MAX_MS * 1000 * CORE_CLK_MHZ;
	localparam int LOCK_CNT_W    = 25;

	// Index of each sampled pin in the synchroniser
	localparam int PIN_SCL   = 0;
	localparam int PIN_SDA   = 1;
	localparam int PIN_DESEL = 2;
	localparam int PIN_RXV   = 3;
	localparam int PIN_N     = 4;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK  = 3'b010,
		S_WRX  = 3'b011,
		S_TX   = 3'b100,
		S_RACK = 3'b101
	} dts_state_t;

	typedef struct packed {
		logic [PIN_N-1:0]                   meta;
		logic [PIN_N-1:0]                   sync;
		logic                               scl_prev;
		logic                               sda_prev;
		dts_state_t                         state;
		logic [3:0]                         bitcnt;
		logic [BYTE_W-1:0]                  shift;
		logic                               rw;
		logic                               have_off;
		logic                               cont;
		logic [PTR_W-1:0]                   ptr;
		logic                               sda_o;
		logic                               sda_oe_n;
		logic                               fc_mode;
		logic [LOCK_CNT_W-1:0]              lock_cnt;
		logic                               locked;
		logic [MEM_DEPTH-1:0][BYTE_W-1:0]   mem;
	} dts_st_t;

	function automatic logic dts_writable(input logic [PTR_W-1:0] addr);
		return addr < MEM_PROT_BASE;
	endfunction : dts_writable

endpackage : dts_pkg

/* File: dts_slave.sv */
`timescale 1ns/1ps
module dts_slave
	import dts_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DEF,
	parameter int         LOCK_CYCLES = LOCK_TYP_CYC
) (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// Two-wire bus pins
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda,
	output logic      o_sda_oe_n,
	// Module control pins
	input  wire logic i_mod_desel,
	input  wire logic i_rx_sig_valid,
	// Clock recovery status and mode
	output logic      o_fc_reduced_rate_mode,
	output logic      o_clock_recovery_unit_locked
);

	dts_st_t st_q;
	dts_st_t st_d;
	logic    scl_s;
	logic    sda_s;
	logic    desel_s;
	logic    rxv_s;
	logic    scl_rise;
	logic    scl_fall;
	logic    start_det;
	logic    stop_det;
	logic    cfg_bit;
	logic    do_load;
	logic    tx_load;
	logic    off_load;
	logic    wr_commit;

	assign scl_s     = st_q.sync[PIN_SCL];
	assign sda_s     = st_q.sync[PIN_SDA];
	assign desel_s   = st_q.sync[PIN_DESEL];
	assign rxv_s     = st_q.sync[PIN_RXV];
	assign scl_rise  = scl_s & ~st_q.scl_prev;
	assign scl_fall  = ~scl_s & st_q.scl_prev;
	assign start_det = scl_s & st_q.scl_prev & st_q.sda_prev & ~sda_s;
	assign stop_det  = scl_s & st_q.scl_prev & ~st_q.sda_prev & sda_s;
	assign cfg_bit   = st_q.mem[CFG_RATE_SEL_OFS][CFG_RATE_BIT];

	always_comb begin
		st_d      = st_q;
		do_load   = 1'b0;
		tx_load   = 1'b0;
		off_load  = 1'b0;
		wr_commit = 1'b0;
		st_d.meta = {i_rx_sig_valid, i_mod_desel, i_sda, i_scl};
		st_d.sync = st_q.meta;
		st_d.scl_prev = scl_s;
		st_d.sda_prev = sda_s;
		st_d.sda_o    = 1'b0;
		if (desel_s) begin
			st_d.state    = S_IDLE;
			st_d.sda_oe_n = 1'b1;
		end else if (start_det) begin
			// Repeated start also lands here and keeps the pointer
			st_d.state    = S_ADDR;
			st_d.bitcnt   = 4'h0;
			st_d.have_off = 1'b0;
			st_d.sda_oe_n = 1'b1;
		end else if (stop_det) begin
			st_d.state    = S_IDLE;
			st_d.sda_oe_n = 1'b1;
		end else begin
			case (st_q.state)
				S_ADDR, S_WRX: begin
					if (scl_rise && st_q.bitcnt < 4'(BITS_PER_BYTE)) begin
						st_d.shift  = {st_q.shift[6:0], sda_s};
						st_d.bitcnt = st_q.bitcnt + 4'h1;
					end else if (scl_fall && st_q.bitcnt == 4'(BITS_PER_BYTE)) begin
						if (st_q.state == S_ADDR) begin
							if (st_q.shift[7:1] == DEV_ADDR) begin
								st_d.rw       = st_q.shift[0];
								st_d.sda_oe_n = 1'b0;
								st_d.state    = S_ACK;
							end else begin
								st_d.state = S_IDLE;
							end
						end else begin
							st_d.sda_oe_n = 1'b0;
							st_d.state    = S_ACK;
							if (!st_q.have_off) begin
								off_load      = 1'b1;
								st_d.ptr      = st_q.shift;
								st_d.have_off = 1'b1;
							end else begin
								wr_commit = 1'b1;
								if (dts_writable(st_q.ptr)) begin
									st_d.mem[st_q.ptr] = st_q.shift;
								end
								st_d.ptr = st_q.ptr + 8'h01;
							end
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						st_d.bitcnt = 4'h0;
						if (st_q.rw) begin
							do_load = 1'b1;
						end else begin
							st_d.sda_oe_n = 1'b1;
							st_d.state    = S_WRX;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (st_q.bitcnt == 4'(BITS_PER_BYTE - 1)) begin
							st_d.sda_oe_n = 1'b1;
							st_d.state    = S_RACK;
						end else begin
							st_d.shift    = {st_q.shift[6:0], 1'b0};
							st_d.sda_oe_n = st_q.shift[6];
							st_d.bitcnt   = st_q.bitcnt + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						st_d.cont = ~sda_s;
					end else if (scl_fall) begin
						if (st_q.cont) begin
							do_load = 1'b1;
						end else begin
							st_d.state = S_IDLE;
						end
					end
				end
				default: begin
					st_d.state    = S_IDLE;
					st_d.sda_oe_n = 1'b1;
				end
			endcase
		end
		// first read bit launched on fall
		if (do_load) begin
			tx_load       = 1'b1;
			st_d.shift    = st_q.mem[st_q.ptr];
			st_d.sda_oe_n = st_q.mem[st_q.ptr][7];
			st_d.ptr      = st_q.ptr + 8'h01;
			st_d.bitcnt   = 4'h0;
			st_d.state    = S_TX;
		end
		st_d.fc_mode = cfg_bit;
		// lock timer restarts on loss or mode change
		if (!rxv_s || st_q.fc_mode != cfg_bit) begin
			st_d.lock_cnt = '0;
			st_d.locked   = 1'b0;
		end else if (!st_q.locked) begin
			if (st_q.lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
				st_d.locked = 1'b1;
			end else begin
				st_d.lock_cnt = st_q.lock_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q          <= '0;
			st_q.state    <= S_IDLE;
			st_q.sda_oe_n <= 1'b1;
			st_q.meta     <= 4'h3;
			st_q.sync     <= 4'h3;
			st_q.scl_prev <= 1'b1;
			st_q.sda_prev <= 1'b1;
			st_q.mem[CFG_RATE_SEL_OFS] <= CFG_RATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Open drain: only ever pull low, never drive high
	assign o_sda                        = st_q.sda_o;
	assign o_sda_oe_n                   = st_q.sda_oe_n;
	assign o_fc_reduced_rate_mode       = st_q.fc_mode;
	assign o_clock_recovery_unit_locked = st_q.locked;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_shift_on_rise;
		(st_q.state == S_ADDR || st_q.state == S_WRX) && !scl_rise && !start_det
			&& !desel_s ##1 st_q.state == S_ADDR || st_q.state == S_WRX
			|-> $stable(st_q.bitcnt) || $past(start_det) || $past(scl_fall);
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise)
		else $error("bit count moved without a rising clock");

	property p_drive_on_fall;
		$fell(o_sda_oe_n) |-> $past(scl_fall);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall)
		else $error("data line driven away from a falling clock");

	property p_stop_idle;
		stop_det && !desel_s && !start_det |=> st_q.state == S_IDLE && o_sda_oe_n;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not return slave to idle");

	property p_start_addr;
		start_det && !desel_s |=> st_q.state == S_ADDR && st_q.bitcnt == 4'h0;
	endproperty
	a_start_addr: assert property (p_start_addr)
		else $error("start did not open address phase");

	property p_read_advance;
		logic [7:0] p;
		(tx_load, p = st_q.ptr) |=> st_q.ptr == p + 8'h01 && st_q.state == S_TX;
	endproperty
	a_read_advance: assert property (p_read_advance)
		else $error("read pointer did not advance by one");

	property p_offset_load;
		logic [7:0] b;
		(off_load, b = st_q.shift) |=> st_q.ptr == b ##1 st_q.have_off;
	endproperty
	a_offset_load: assert property (p_offset_load)
		else $error("offset byte not taken as pointer");

	property p_rate_mode;
		cfg_bit != o_fc_reduced_rate_mode |=> o_fc_reduced_rate_mode == $past(cfg_bit)
			&& !o_clock_recovery_unit_locked;
	endproperty
	a_rate_mode: assert property (p_rate_mode)
		else $error("rate mode did not follow config bit");

	property p_lock_loss;
		!rxv_s |=> !o_clock_recovery_unit_locked && st_q.lock_cnt == '0;
	endproperty
	a_lock_loss: assert property (p_lock_loss)
		else $error("lock held without valid input");

	property p_lock_bound;
		st_q.lock_cnt < LOCK_CNT_W'(LOCK_MAX_CYC);
	endproperty
	a_lock_bound: assert property (p_lock_bound)
		else $error("lock time exceeds maximum");

	property p_desel_quiet;
		desel_s |=> o_sda_oe_n && st_q.state == S_IDLE;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet)
		else $error("slave active while deselected");

	// Any protected location, not just the first one, must keep its byte
	property p_prot_stable;
		logic [PTR_W-1:0]  pa;
		logic [BYTE_W-1:0] pv;
		(wr_commit && !dts_writable(st_q.ptr), pa = st_q.ptr, pv = st_q.mem[st_q.ptr])
			|=> st_q.mem[pa] == pv && st_q.state == S_ACK;
	endproperty
	a_prot_stable: assert property (p_prot_stable)
		else $error("protected location changed on write");

	c_read_burst: cover property (tx_load ##[1:1000] tx_load);
	c_cfg_write:  cover property (wr_commit && st_q.ptr == CFG_RATE_SEL_OFS);
	c_lock:       cover property ($rose(o_clock_recovery_unit_locked));
	c_nack_stop:  cover property (st_q.state == S_RACK && scl_fall && !st_q.cont);

endmodule : dts_slave

/* File: dts_host.sv */
`timescale 1ns/1ps
module dts_host (
	// Two-wire bus pins
	output logic      o_scl,
	output logic      o_sda_rel,
	input  wire logic i_sda
);
	// Idle bus: clock parked high, data released to the pull-up
	initial begin
		o_scl     = 1'b1;
		o_sda_rel = 1'b1;
	end

	task automatic bit_io(input logic b, output logic r);
		#4 o_sda_rel = b;
		#12 o_scl = 1'b1;
		#8 r = i_sda;
		#8 o_scl = 1'b0;
	endtask : bit_io

	task automatic start();
		#4 o_sda_rel = 1'b1;
		#12 o_scl = 1'b1;
		#16 o_sda_rel = 1'b0;
		#16 o_scl = 1'b0;
	endtask : start

	task automatic stop();
		#4 o_sda_rel = 1'b0;
		#12 o_scl = 1'b1;
		#16 o_sda_rel = 1'b1;
		#16;
	endtask : stop

	// Eight bits then the ninth acknowledge bit
	task automatic xbyte(input logic [7:0] d, input logic a_in,
			output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a_in, ak);
	endtask : xbyte
endmodule : dts_host

/* File: tb_module_diag_two_wire_slave.sv */
`timescale 1ns/1ps
module tb_module_diag_two_wire_slave;
	import dts_pkg::*;
	localparam int LOCK_N = 50;
	logic clk, rst, desel, rxv, scl, sda_rel, sda_o, oe_n, fc, lck, sda;
	int   fail_count, total_checks, seed, mdl[256];

	// Open-drain wire with pull-up
	assign sda = sda_rel & (oe_n | sda_o);
	initial clk = 1'b0;
	always #2 clk = ~clk;

	dts_slave #(.LOCK_CYCLES(LOCK_N)) dut (
		.i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
		.o_sda(sda_o), .o_sda_oe_n(oe_n), .i_mod_desel(desel),
		.i_rx_sig_valid(rxv), .o_fc_reduced_rate_mode(fc),
		.o_clock_recovery_unit_locked(lck));
	dts_host h (.o_scl(scl), .o_sda_rel(sda_rel), .i_sda(sda));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	task automatic head(input logic [6:0] a, input logic [7:0] off, input logic nak);
		logic [7:0] q;
		logic       ak;
		h.start();
		h.xbyte({a, 1'b0}, 1'b1, q, ak);
		chk({7'h0, ak}, {7'h0, nak});
		h.xbyte(off, 1'b1, q, ak);
		chk({7'h0, ak}, {7'h0, nak});
	endtask : head

	task automatic wr(input logic [7:0] off, input int n, input logic [7:0] d0,
			input logic sel);
		logic [7:0] q, d;
		logic       ak;
		head(DEV_ADDR_DEF, off, ~sel);
		for (int i = 0; i < n; i++) begin
			d = (i == 0) ? d0 : 8'($random(seed));
			h.xbyte(d, 1'b1, q, ak);
			chk({7'h0, ak}, {7'h0, ~sel});
			if (sel && off < MEM_PROT_BASE) begin
				mdl[off] = d;
			end
			off++;
		end
		h.stop();
		chk({7'h0, fc}, 8'(mdl[117] & 1));
	endtask : wr

	task automatic rd(input logic [7:0] off, input int n);
		logic [7:0] q;
		logic       ak;
		head(DEV_ADDR_DEF, off, 1'b0);
		h.start();
		h.xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, q, ak);
		chk({7'h0, ak}, 8'h00);
		for (int i = 0; i < n; i++) begin
			h.xbyte(8'hFF, i == n - 1, q, ak);
			chk(q, mdl[off][7:0]);
			off++;
		end
		h.stop();
	endtask : rd

	initial begin
		seed = 32'h2a69129b;
		rst = 1'b1;
		desel = 1'b0;
		rxv = 1'b0;
		fail_count = 0;
		total_checks = 0;
		foreach (mdl[i]) mdl[i] = 0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk({6'h0, fc, lck}, 8'h00);
		chk({7'h0, oe_n}, 8'h01);
		repeat (4) @(negedge clk);
		wr(8'h7C, 6, 8'($random(seed)), 1'b1);
		rd(8'h7C, 6);
		for (int k = 0; k < 6; k++) begin
			wr(8'($random(seed)), 1 + k % 3, 8'($random(seed)), 1'b1);
		end
		wr(CFG_RATE_SEL_OFS, 1, 8'h01, 1'b1);
		wr(CFG_RATE_SEL_OFS, 1, 8'hFE, 1'b1);
		rd(8'h00, 130);
		rd(8'hFE, 4);
		head(DEV_ADDR_DEF ^ 7'h01, 8'h10, 1'b1);
		h.stop();
		@(negedge clk);
		desel = 1'b1;
		wr(8'h10, 2, 8'h5A, 1'b0);
		@(negedge clk);
		desel = 1'b0;
		rd(8'h10, 2);
		@(negedge clk);
		rxv = 1'b1;
		repeat (40) @(negedge clk);
		chk({7'h0, lck}, 8'h00);
		repeat (20) @(negedge clk);
		chk({7'h0, lck}, 8'h01);
		rxv = 1'b0;
		repeat (6) @(negedge clk);
		chk({7'h0, lck}, 8'h00);
		test_done();
	end

	// Whole run needs about 60 us; a hang stops well inside the cycle budget
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
endmodule : tb_module_diag_two_wire_slave
